// *** design/ild_alias_match.sv ***
// masked address comparator used for every legacy port window
module ild_alias_match (
  input  wire logic [ild_pkg::ADDR_W-1:0] addr,
  input  wire logic [ild_pkg::ADDR_W-1:0] base,
  input  wire logic [ild_pkg::ADDR_W-1:0] dont_care,
  output logic                            hit
);

  // bits set in dont_care select among aliases and registers
  assign hit = ((addr ^ base) & ~dont_care) == '0;

endmodule

// *** design/ild_decoder.sv ***
// legacy isa-compatible i/o address decoder with rtc configuration byte
module ild_decoder (
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  input  wire logic                         clk_en,
  input  wire logic                         io_valid,
  input  wire logic                         io_write,
  input  wire logic [ild_pkg::ADDR_W-1:0]   io_addr,
  input  wire logic                         page_alias_en,
  input  wire logic                         cfg_valid,
  input  wire logic                         cfg_write,
  input  wire logic [ild_pkg::CFG_W-1:0]    cfg_addr,
  input  wire logic [ild_pkg::DATA_W-1:0]   cfg_wdata,
  output logic [ild_pkg::DATA_W-1:0]        cfg_rdata,
  output logic                              dec_valid,
  output ild_pkg::ild_target_t              dec_target,
  output logic                              dec_internal,
  output logic                              dec_isa_fwd,
  output logic                              dec_ddma_ok,
  output logic                              dec_wo_read
);

  function automatic logic in_range(input logic [3:0] v, input logic [3:0] lo,
                                    input logic [3:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // page slots without a real channel behind them
  function automatic logic page_reserved(input logic [3:0] v);
    page_reserved = (v == 4'h0) || (v == 4'h4) || (v == 4'h5) || (v == 4'h6) ||
                    (v == 4'h8) || (v == 4'hC) || (v == 4'hD) || (v == 4'hE);
  endfunction

  logic [ild_pkg::DATA_W-1:0] rtc_configuration_reg;
  logic [ild_pkg::DATA_W-1:0] rtc_configuration_next;
  logic [ild_pkg::DATA_W-1:0] cfg_rdata_next;
  logic                       dec_valid_reg;
  ild_pkg::ild_target_t       dec_target_reg;
  logic                       dec_internal_reg;
  logic                       dec_isa_fwd_reg;
  logic                       dec_ddma_ok_reg;
  logic                       dec_wo_read_reg;
  logic [ild_pkg::DATA_W-1:0] cfg_rdata_reg;

  wire rtc_int_en  = rtc_configuration_reg[ild_pkg::RTC_CFG_INT_EN_BIT];
  wire ext_ram_en  = rtc_configuration_reg[ild_pkg::RTC_CFG_EXT_RAM_BIT];
  wire cfg_sel     = cfg_valid && (cfg_addr == ild_pkg::RTC_CONFIGURATION_OFS);
  wire [3:0] low_n = io_addr[3:0];

  // the rtc mask narrows with the extended ram enable, the page mask widens with the page alias enable
  wire [ild_pkg::ADDR_W-1:0] rtc_dc  = ext_ram_en ? ild_pkg::RTC_DC_EXT
                                                  : ild_pkg::RTC_DC_FULL;
  wire [ild_pkg::ADDR_W-1:0] page_dc = page_alias_en ? ild_pkg::PAGE_DC_ALIAS
                                                     : ild_pkg::PAGE_DC;

  logic hit_fdma, hit_pic1, hit_pit, hit_kbd, hit_nmi, hit_ridx, hit_rdat;
  logic hit_xidx, hit_xdat, hit_page, hit_p92, hit_pic2, hit_apm, hit_sdma;
  logic hit_fpu, hit_elcr, hit_rstc;

  ild_alias_match u_fdma (.addr(io_addr), .base(ild_pkg::FIRST_DMA_BASE),
                          .dont_care(ild_pkg::FIRST_DMA_DC), .hit(hit_fdma));
  ild_alias_match u_pic1 (.addr(io_addr), .base(ild_pkg::PIC1_BASE),
                          .dont_care(ild_pkg::PIC_DC), .hit(hit_pic1));
  ild_alias_match u_pit  (.addr(io_addr), .base(ild_pkg::PIT_BASE),
                          .dont_care(ild_pkg::PIT_DC), .hit(hit_pit));
  ild_alias_match u_kbd  (.addr(io_addr), .base(ild_pkg::KBD_RST_ADDR),
                          .dont_care(ild_pkg::NO_DC), .hit(hit_kbd));
  ild_alias_match u_nmi  (.addr(io_addr), .base(ild_pkg::NMI_BASE),
                          .dont_care(ild_pkg::NMI_DC), .hit(hit_nmi));
  ild_alias_match u_ridx (.addr(io_addr), .base(ild_pkg::RTC_IDX_BASE),
                          .dont_care(rtc_dc), .hit(hit_ridx));
  ild_alias_match u_rdat (.addr(io_addr), .base(ild_pkg::RTC_DATA_BASE),
                          .dont_care(rtc_dc), .hit(hit_rdat));
  ild_alias_match u_xidx (.addr(io_addr), .base(ild_pkg::RTC_EXT_IDX),
                          .dont_care(ild_pkg::NO_DC), .hit(hit_xidx));
  ild_alias_match u_xdat (.addr(io_addr), .base(ild_pkg::RTC_EXT_DATA),
                          .dont_care(ild_pkg::NO_DC), .hit(hit_xdat));
  ild_alias_match u_page (.addr(io_addr), .base(ild_pkg::PAGE_BASE),
                          .dont_care(page_dc), .hit(hit_page));
  ild_alias_match u_p92  (.addr(io_addr), .base(ild_pkg::PORT92_ADDR),
                          .dont_care(ild_pkg::NO_DC), .hit(hit_p92));
  ild_alias_match u_pic2 (.addr(io_addr), .base(ild_pkg::PIC2_BASE),
                          .dont_care(ild_pkg::PIC_DC), .hit(hit_pic2));
  ild_alias_match u_apm  (.addr(io_addr), .base(ild_pkg::APM_BASE),
                          .dont_care(ild_pkg::APM_DC), .hit(hit_apm));
  ild_alias_match u_sdma (.addr(io_addr), .base(ild_pkg::SECOND_DMA_BASE),
                          .dont_care(ild_pkg::SECOND_DMA_DC), .hit(hit_sdma));
  ild_alias_match u_fpu  (.addr(io_addr), .base(ild_pkg::FPU_ERR_ADDR),
                          .dont_care(ild_pkg::NO_DC), .hit(hit_fpu));
  ild_alias_match u_elcr (.addr(io_addr), .base(ild_pkg::ELCR_BASE),
                          .dont_care(ild_pkg::ELCR_DC), .hit(hit_elcr));
  ild_alias_match u_rstc (.addr(io_addr), .base(ild_pkg::RESET_CTL_ADDR),
                          .dont_care(ild_pkg::NO_DC), .hit(hit_rstc));

  // 92h is port 92, and 82h has no alias in the 9xh window
  wire in_alias_half = (io_addr & ild_pkg::PAGE_ALIAS_BIT) != '0;
  wire page_ok       = hit_page && !hit_p92 && (io_addr != ild_pkg::PAGE_NOALIAS);
  wire page_rsvd     = page_ok && page_reserved(low_n);
  wire xram_hit      = ext_ram_en && (hit_xidx || hit_xdat);

  // the controller register index is the byte address over two
  wire [3:0] sdma_idx = io_addr[4:1];
  wire fdma_wo = hit_fdma &&
                 in_range(low_n, ild_pkg::FIRST_DMA_WO_LO, ild_pkg::FIRST_DMA_WO_HI);
  wire sdma_wo = hit_sdma &&
                 in_range(sdma_idx, ild_pkg::SECOND_DMA_WO_LO, ild_pkg::SECOND_DMA_WO_HI);
  wire pit_wo  = hit_pit && ((io_addr & ~ild_pkg::PIT_DC) ==
                 (ild_pkg::PIT_BASE & ~ild_pkg::PIT_DC)) &&
                 (io_addr[1:0] == ild_pkg::PIT_CTRL_ADDR[1:0]);
  wire rtc_wo  = hit_ridx && !xram_hit;
  wire any_wo  = fdma_wo || sdma_wo || pit_wo || rtc_wo || hit_fpu;

  ild_pkg::ild_target_t tgt;
  assign tgt = hit_fdma  ? ild_pkg::ILD_TGT_FIRST_DMA :
               hit_pic1  ? ild_pkg::ILD_TGT_PIC1 :
               hit_pit   ? ild_pkg::ILD_TGT_PIT :
               hit_kbd   ? ild_pkg::ILD_TGT_KBD_RST :
               hit_nmi   ? ild_pkg::ILD_TGT_NMI :
               (xram_hit && hit_xidx) ? ild_pkg::ILD_TGT_RTC_XIDX :
               (xram_hit && hit_xdat) ? ild_pkg::ILD_TGT_RTC_XDATA :
               hit_ridx  ? ild_pkg::ILD_TGT_RTC_IDX :
               hit_rdat  ? ild_pkg::ILD_TGT_RTC_DATA :
               hit_p92   ? ild_pkg::ILD_TGT_PORT92 :
               page_rsvd ? ild_pkg::ILD_TGT_PAGE_RSVD :
               page_ok   ? ild_pkg::ILD_TGT_PAGE :
               hit_pic2  ? ild_pkg::ILD_TGT_PIC2 :
               hit_apm   ? ild_pkg::ILD_TGT_APM :
               hit_sdma  ? ild_pkg::ILD_TGT_SECOND_DMA :
               hit_fpu   ? ild_pkg::ILD_TGT_FPU_ERR :
               hit_elcr  ? ild_pkg::ILD_TGT_ELCR :
               hit_rstc  ? ild_pkg::ILD_TGT_RESET_CTL :
                           ild_pkg::ILD_TGT_NONE;

  wire rtc_std  = (tgt == ild_pkg::ILD_TGT_RTC_IDX) || (tgt == ild_pkg::ILD_TGT_RTC_DATA);
  wire fwd_always = (tgt == ild_pkg::ILD_TGT_KBD_RST) || (tgt == ild_pkg::ILD_TGT_FPU_ERR);
  wire fwd_rtc    = rtc_std && !rtc_int_en;
  // reserved pages in the alias half belong to the isa bus outright
  wire rsvd_isa   = page_rsvd && in_alias_half;
  wire fwd_rsvd   = page_rsvd && (io_write || in_alias_half);
  wire isa_fwd    = fwd_always || fwd_rtc || fwd_rsvd;
  wire internal   = (tgt != ild_pkg::ILD_TGT_NONE) && !rsvd_isa && !fwd_rtc;
  // distributed dma only through the primary page window
  wire ddma_ok    = page_ok && !in_alias_half;

  assign rtc_configuration_next = (cfg_sel && cfg_write)
                                ? (cfg_wdata & ild_pkg::RTC_CFG_WR_MASK)
                                : rtc_configuration_reg;
  // unmapped configuration offsets read as zero
  assign cfg_rdata_next = (cfg_sel && !cfg_write) ? rtc_configuration_reg : '0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rtc_configuration_reg <= ild_pkg::RTC_CONFIGURATION_RST;
      cfg_rdata_reg         <= '0;
    end else if (clk_en) begin
      rtc_configuration_reg <= rtc_configuration_next;
      cfg_rdata_reg         <= cfg_rdata_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      dec_valid_reg    <= 1'b0;
      dec_target_reg   <= ild_pkg::ILD_TGT_NONE;
      dec_internal_reg <= 1'b0;
      dec_isa_fwd_reg  <= 1'b0;
      dec_ddma_ok_reg  <= 1'b0;
      dec_wo_read_reg  <= 1'b0;
    end else if (clk_en) begin
      dec_valid_reg    <= io_valid;
      dec_target_reg   <= io_valid ? tgt : ild_pkg::ILD_TGT_NONE;
      dec_internal_reg <= io_valid && internal;
      dec_isa_fwd_reg  <= io_valid && isa_fwd;
      dec_ddma_ok_reg  <= io_valid && ddma_ok;
      dec_wo_read_reg  <= io_valid && !io_write && any_wo;
    end
  end

  assign cfg_rdata    = cfg_rdata_reg;
  assign dec_valid    = dec_valid_reg;
  assign dec_target   = dec_target_reg;
  assign dec_internal = dec_internal_reg;
  assign dec_isa_fwd  = dec_isa_fwd_reg;
  assign dec_ddma_ok  = dec_ddma_ok_reg;
  assign dec_wo_read  = dec_wo_read_reg;

endmodule

// *** design/ild_pkg.sv ***
// constants, target codes and behaviour summary for the legacy i/o decoder
//
// Behaviour
// - keyboard reset and coprocessor ports always reach isa
// - rtc ports reach isa only when internal rtc off
// - extended ram drops 0072h/0076h as index aliases
// - extended ram drops 0073h/0077h as data aliases
// - no distributed dma for page aliases at 90h
// - reserved page writes forwarded, reads at 8xh kept off isa
// - with aliasing, reserved 9xh pages are isa registers
// - first dma ports aliased +10h; command ports write-only
// - first interrupt controller aliased every four bytes
// - second interrupt controller aliased every four bytes
// - timer ports aliased +10h; control port write-only
// - nmi status port also at 63h, 65h, 67h
// - second dma registers also answer at odd address
package ild_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CFG_W  = 8;

  // configuration space location of the clock configuration byte
  localparam logic [CFG_W-1:0]  RTC_CONFIGURATION_OFS = 8'hCB;
  localparam logic [DATA_W-1:0] RTC_CONFIGURATION_RST = 8'h01;
  localparam int unsigned       RTC_CFG_INT_EN_BIT    = 0;
  localparam int unsigned       RTC_CFG_EXT_RAM_BIT   = 2;
  localparam logic [DATA_W-1:0] RTC_CFG_WR_MASK       = 8'h05;

  // base addresses and don't-care masks
  localparam logic [ADDR_W-1:0] FIRST_DMA_BASE  = 16'h0000;
  localparam logic [ADDR_W-1:0] FIRST_DMA_DC    = 16'h001F;
  localparam logic [ADDR_W-1:0] PIC1_BASE       = 16'h0020;
  localparam logic [ADDR_W-1:0] PIC_DC          = 16'h001D;
  localparam logic [ADDR_W-1:0] PIT_BASE        = 16'h0040;
  localparam logic [ADDR_W-1:0] PIT_DC          = 16'h0013;
  localparam logic [ADDR_W-1:0] PIT_CTRL_ADDR   = 16'h0003;
  localparam logic [ADDR_W-1:0] KBD_RST_ADDR    = 16'h0060;
  localparam logic [ADDR_W-1:0] NMI_BASE        = 16'h0061;
  localparam logic [ADDR_W-1:0] NMI_DC          = 16'h0006;
  localparam logic [ADDR_W-1:0] RTC_IDX_BASE    = 16'h0070;
  localparam logic [ADDR_W-1:0] RTC_DATA_BASE   = 16'h0071;
  localparam logic [ADDR_W-1:0] RTC_DC_FULL     = 16'h0006;
  localparam logic [ADDR_W-1:0] RTC_DC_EXT      = 16'h0004;
  localparam logic [ADDR_W-1:0] RTC_EXT_IDX     = 16'h0072;
  localparam logic [ADDR_W-1:0] RTC_EXT_DATA    = 16'h0073;
  localparam logic [ADDR_W-1:0] PAGE_BASE       = 16'h0080;
  localparam logic [ADDR_W-1:0] PAGE_DC         = 16'h000F;
  localparam logic [ADDR_W-1:0] PAGE_DC_ALIAS   = 16'h001F;
  localparam logic [ADDR_W-1:0] PAGE_NOALIAS    = 16'h0092;
  localparam logic [ADDR_W-1:0] PORT92_ADDR     = 16'h0092;
  localparam logic [ADDR_W-1:0] PAGE_ALIAS_BIT  = 16'h0010;
  localparam logic [ADDR_W-1:0] PIC2_BASE       = 16'h00A0;
  localparam logic [ADDR_W-1:0] APM_BASE        = 16'h00B2;
  localparam logic [ADDR_W-1:0] APM_DC          = 16'h0001;
  localparam logic [ADDR_W-1:0] SECOND_DMA_BASE = 16'h00C0;
  localparam logic [ADDR_W-1:0] SECOND_DMA_DC   = 16'h001F;
  localparam logic [ADDR_W-1:0] FPU_ERR_ADDR    = 16'h00F0;
  localparam logic [ADDR_W-1:0] ELCR_BASE       = 16'h04D0;
  localparam logic [ADDR_W-1:0] ELCR_DC         = 16'h0001;
  localparam logic [ADDR_W-1:0] RESET_CTL_ADDR  = 16'h0CF9;
  localparam logic [ADDR_W-1:0] NO_DC           = 16'h0000;

  // write-only register index ranges inside a controller window
  localparam logic [3:0] FIRST_DMA_WO_LO  = 4'h9;
  localparam logic [3:0] FIRST_DMA_WO_HI  = 4'hE;
  localparam logic [3:0] SECOND_DMA_WO_LO = 4'h9;
  localparam logic [3:0] SECOND_DMA_WO_HI = 4'hE;

  typedef enum logic [4:0] {
    ILD_TGT_NONE       = 5'b00000,
    ILD_TGT_FIRST_DMA  = 5'b00001,
    ILD_TGT_PIC1       = 5'b00010,
    ILD_TGT_PIT        = 5'b00011,
    ILD_TGT_KBD_RST    = 5'b00100,
    ILD_TGT_NMI        = 5'b00101,
    ILD_TGT_RTC_IDX    = 5'b00110,
    ILD_TGT_RTC_DATA   = 5'b00111,
    ILD_TGT_RTC_XIDX   = 5'b01000,
    ILD_TGT_RTC_XDATA  = 5'b01001,
    ILD_TGT_PAGE       = 5'b01010,
    ILD_TGT_PAGE_RSVD  = 5'b01011,
    ILD_TGT_PORT92     = 5'b01100,
    ILD_TGT_PIC2       = 5'b01101,
    ILD_TGT_APM        = 5'b01110,
    ILD_TGT_SECOND_DMA = 5'b01111,
    ILD_TGT_FPU_ERR    = 5'b10000,
    ILD_TGT_ELCR       = 5'b10001,
    ILD_TGT_RESET_CTL  = 5'b10010
  } ild_target_t;

endpackage

// *** sim/ild_decoder_bench.sv ***
// self-checking bench for the legacy i/o decoder
module ild_decoder_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, page_alias_en = 1'b0;
  logic        cfg_valid = 1'b0, cfg_write = 1'b0, io_valid, io_write;
  logic [7:0]  cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
  logic        dec_valid, dec_internal, dec_isa_fwd, dec_ddma_ok, dec_wo_read;
  logic [15:0] io_addr, ofs;
  ild_pkg::ild_target_t dec_target;
  int          failures = 0, checked = 0, cycles = 0;
  ild_pci_host ild_pci_host_inst (.core_clk(core_clk), .io_valid(io_valid),
    .io_write(io_write), .io_addr(io_addr));
  ild_decoder ild_decoder_inst (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .io_valid(io_valid), .io_write(io_write), .io_addr(io_addr), .page_alias_en(page_alias_en),
    .cfg_valid(cfg_valid), .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .dec_valid(dec_valid), .dec_target(dec_target),
    .dec_internal(dec_internal), .dec_isa_fwd(dec_isa_fwd), .dec_ddma_ok(dec_ddma_ok),
    .dec_wo_read(dec_wo_read));
  initial forever #5 core_clk = ~core_clk;
  task automatic give_verdict();
    if (failures == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // the sequence needs well under 1000 cycles
  always @(posedge core_clk) begin
    cycles++;
    failures += int'(cycles > 4000);
    if (cycles > 4000) give_verdict();
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    if ($isunknown(e)) return; // x expected leaves the field unchecked
    checked++;
    failures += int'(g !== e);
    if (g !== e) $display("Error %s expected %h seen %h", n, e, g);
  endtask
  task automatic io(input logic [15:0] a, input logic w, input ild_pkg::ild_target_t t,
                    input logic f, input logic wo);
    ild_pci_host_inst.issue(a, w);
    chk("dec_valid", 8'h01, {7'h00, dec_valid});
    chk("dec_target", 8'(t), 8'(dec_target));
    chk("dec_isa_fwd", {7'h00, f}, {7'h00, dec_isa_fwd});
    chk("dec_wo_read", {7'h00, wo}, {7'h00, dec_wo_read});
  endtask
  task automatic cfg(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {cfg_valid, cfg_write, cfg_addr, cfg_wdata} <= {1'b1, w, a, d};
    @(posedge core_clk);
    cfg_valid <= 1'b0;
    #1;
    if (!w) chk("cfg_rdata", d, cfg_rdata);
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    cfg(1'b0, 8'hCB, 8'h01);
    cfg(1'b0, 8'hC0, 8'h00);
    cfg(1'b1, 8'hCB, 8'hFF);
    cfg(1'b0, 8'hCB, 8'h05);
    io(16'h0076, 1'b1, ild_pkg::ILD_TGT_NONE, 1'b0, 1'b0);
    io(16'h0073, 1'b0, ild_pkg::ILD_TGT_RTC_XDATA, 1'b0, 1'b0);
    cfg(1'b1, 8'hCB, 8'h00);
    io(16'h0075, 1'b0, ild_pkg::ILD_TGT_RTC_DATA, 1'b1, 1'b0);
    io(16'h0076, 1'b0, ild_pkg::ILD_TGT_RTC_IDX, 1'b1, 1'b1);
    cfg(1'b1, 8'hCB, 8'h01);
    io(16'h0074, 1'b1, ild_pkg::ILD_TGT_RTC_IDX, 1'b0, 1'b0);
    io(16'h0060, 1'b0, ild_pkg::ILD_TGT_KBD_RST, 1'b1, 1'b0);
    io(16'h00F0, 1'b1, ild_pkg::ILD_TGT_FPU_ERR, 1'b1, 1'b0);
    for (int i = 0; i < 32; i++) begin
      ofs = 16'(i / 2 * 4 + i % 2);
      io(16'(i), 1'b0, ild_pkg::ILD_TGT_FIRST_DMA, 1'bx, i[3:0] inside {[9:14]});
      io(16'h00C0 + 16'(i), 1'b0, ild_pkg::ILD_TGT_SECOND_DMA, 1'bx,
         i[4:1] inside {[9:14]});
      if (i < 16) io(16'h0020 + ofs, i[0], ild_pkg::ILD_TGT_PIC1, 1'bx, 1'b0);
      if (i < 16) io(16'h00A0 + ofs, i[0], ild_pkg::ILD_TGT_PIC2, 1'bx, 1'b0);
      if (i < 8) io(16'h0040 + 16'(i[2] * 16 + i[1:0]), 1'b0, ild_pkg::ILD_TGT_PIT, 1'bx,
                    i[1:0] == 2'd3);
      if (i < 4) io(16'h0061 + 16'(2 * i), 1'b0, ild_pkg::ILD_TGT_NMI, 1'bx, 1'b0);
    end
    io(16'h0084, 1'b1, ild_pkg::ILD_TGT_PAGE_RSVD, 1'b1, 1'b0);
    io(16'h008C, 1'b0, ild_pkg::ILD_TGT_PAGE_RSVD, 1'b0, 1'b0);
    io(16'h0081, 1'b0, ild_pkg::ILD_TGT_PAGE, 1'bx, 1'b0);
    chk("dec_ddma_ok", 8'h01, {7'h00, dec_ddma_ok});
    @(posedge core_clk) page_alias_en <= 1'b1;
    io(16'h0091, 1'b0, ild_pkg::ILD_TGT_PAGE, 1'bx, 1'b0);
    chk("dec_ddma_ok", 8'h00, {7'h00, dec_ddma_ok});
    io(16'h0094, 1'b0, ild_pkg::ILD_TGT_PAGE_RSVD, 1'b1, 1'b0);
    chk("dec_internal", 8'h00, {7'h00, dec_internal});
    // a low enable must swallow the configuration write
    @(posedge core_clk) clk_en <= 1'b0;
    cfg(1'b1, 8'hCB, 8'h04);
    @(posedge core_clk) clk_en <= 1'b1;
    cfg(1'b0, 8'hCB, 8'h01);
    give_verdict();
  end
endmodule

// *** sim/ild_decoder_props.sv ***
// assertions on the legacy i/o decoder ports
module ild_decoder_props (
  input wire logic                 core_clk,
  input wire logic                 rst,
  input wire logic                 clk_en,
  input wire logic                 io_valid,
  input wire logic                 io_write,
  input wire logic [15:0]          io_addr,
  input wire ild_pkg::ild_target_t dec_target,
  input wire logic                 dec_isa_fwd,
  input wire logic                 dec_ddma_ok,
  input wire logic                 dec_wo_read
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_take;
    clk_en && io_valid;
  endsequence
  a_always_forwarded: assert property (s_take ##0 (io_addr inside {16'h0060, 16'h00F0})
    |=> dec_isa_fwd) else $error("kbd or fpu access not forwarded");
  a_page_alias_ddma: assert property (s_take ##0 (io_addr[15:4] == 12'h009)
    |=> !dec_ddma_ok) else $error("distributed dma granted at 9xh");
  a_rsvd_read_kept: assert property (s_take ##0 (!io_write && io_addr inside
    {16'h0080, 16'h0084, 16'h008C}) |=> !dec_isa_fwd) else $error("reserved page read forwarded");
  a_first_dma_alias: assert property (s_take ##0 (io_addr[15:5] == 11'h000)
    |=> dec_target == ild_pkg::ILD_TGT_FIRST_DMA) else $error("first dma window miss");
  a_pic1_alias: assert property (s_take ##0 (io_addr[15:5] == 11'h001 && !io_addr[1])
    |=> dec_target == ild_pkg::ILD_TGT_PIC1) else $error("first irq controller alias miss");
  a_pic2_alias: assert property (s_take ##0 (io_addr[15:5] == 11'h005 && !io_addr[1])
    |=> dec_target == ild_pkg::ILD_TGT_PIC2) else $error("second irq controller alias miss");
  a_timer_ctrl_wo: assert property (s_take ##0 (!io_write && io_addr[15:5] == 11'h002
    && io_addr[3:0] == 4'h3) |=> dec_wo_read) else $error("timer control read not flagged");
  a_nmi_alias: assert property (s_take ##0 (io_addr[15:3] == 13'h000C && io_addr[0])
    |=> dec_target == ild_pkg::ILD_TGT_NMI) else $error("nmi status alias miss");
  a_second_dma_odd: assert property (s_take ##0 (io_addr[15:5] == 11'h006)
    |=> dec_target == ild_pkg::ILD_TGT_SECOND_DMA) else $error("second dma window miss");
endmodule
bind ild_decoder ild_decoder_props ild_decoder_props_inst (.*);

// *** sim/ild_pci_host.sv ***
// pci host model issuing single i/o address phases
module ild_pci_host (
  input wire logic    core_clk,
  output logic        io_valid = 1'b0,
  output logic        io_write = 1'b0,
  output logic [15:0] io_addr = 16'h0000
);
  timeunit 1ns;
  timeprecision 100ps;
  // released bus shows the inverse so a stale address never matches
  task automatic issue(input logic [15:0] a, input logic w);
    @(posedge core_clk);
    {io_valid, io_write, io_addr} <= {1'b1, w, a};
    @(posedge core_clk);
    {io_valid, io_write, io_addr} <= {1'b0, ~w, ~a};
    #1;
  endtask
endmodule
